// ==== src/lscr_top.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "lscr_cfg.svh"

module lscr_top
	import lscr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [`LSCR_ADDR_W-1:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [`LSCR_DATA_W-1:0] regWrData,
	output logic [`LSCR_DATA_W-1:0] regRdData,
	input wire logic standbyExitPin,
	input wire logic [1:0] overCurrentIn,
	input wire logic [1:0] underVoltageIn,
	input wire logic [1:0] ocClear,
	input wire logic [1:0] uvClear,
	output logic [1:0] ldoEnable,
	output logic [1:0] ldoLowPower,
	output logic [1:0] ldoDischarge,
	output logic [1:0] ocFlag,
	output logic [1:0] uvFlag,
	input wire logic [`LSCR_CUR_W-1:0] thirdCurrentIn,
	input wire logic thirdCurrentValid,
	output logic [`LSCR_CUR_W-1:0] adcCurrentData,
	output logic adcCurrentValid
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [`LSCR_SYNC_W-1:0] syncVec;

	lscr_pin_sync u_sync (
		.mclk(mclk),
		.rst(rst),
		.asyncIn({underVoltageIn, overCurrentIn, standbyExitPin}),
		.syncOut(syncVec)
	);

	logic exitLast_ff, nxt_exitLast, exitRise;

	always_comb begin
		nxt_exitLast = syncVec[0];
		exitRise = syncVec[0] & ~exitLast_ff;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			exitLast_ff <= 1'b0;
		end else begin
			exitLast_ff <= nxt_exitLast;
		end
	end

	// ---------------------------------------------------------------
	// control registers, one per regulator
	// ---------------------------------------------------------------
	lscr_ctrl_s ctrl_ff [`LSCR_NUM_LDO];
	logic [1:0] enable_ff, lowPower_ff, discharge_ff;

	genvar g;
	generate
		for (g = 0; g < `LSCR_NUM_LDO; g++) begin : gLdo
			lscr_ctrl_s nxt_ctrl;
			logic nxt_enable, nxt_lowPower, nxt_discharge;
			logic hit;

			always_comb begin
				hit = (regAddr == lscrAddrOf(g));
				nxt_ctrl = ctrl_ff[g];
				if (regWrEn && hit) begin
					nxt_ctrl.exitCode = regWrData[`LSCR_EXIT_MSB:`LSCR_EXIT_LSB];
					if (lscrIsRunCode(regWrData[`LSCR_LIVE_MSB:`LSCR_LIVE_LSB])) begin
						nxt_ctrl.liveCode = regWrData[`LSCR_LIVE_MSB:`LSCR_LIVE_LSB];
					end
				end
				// standby exit overrides a write landing in the same cycle
				if (exitRise && lscrIsRunCode(ctrl_ff[g].exitCode)) begin
					nxt_ctrl.liveCode = ctrl_ff[g].exitCode;
				end
				nxt_ctrl.rsvd = 2'h0;
				// low power follows the programmed code only; no load sensing here
				nxt_lowPower = (nxt_ctrl.liveCode == `LSCR_CODE_LOWPWR);
				nxt_enable = (nxt_ctrl.liveCode != `LSCR_CODE_OFF);
				nxt_discharge = (nxt_ctrl.liveCode == `LSCR_CODE_OFF);
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					ctrl_ff[g] <= lscrResetOf(g);
					// both reset codes select off, so no rail may glitch on in reset
					enable_ff[g] <= 1'b0;
					lowPower_ff[g] <= 1'b0;
					discharge_ff[g] <= 1'b1;
				end else begin
					ctrl_ff[g] <= nxt_ctrl;
					enable_ff[g] <= nxt_enable;
					lowPower_ff[g] <= nxt_lowPower;
					discharge_ff[g] <= nxt_discharge;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// register read port
	// ---------------------------------------------------------------
	logic [`LSCR_DATA_W-1:0] rdData_ff, nxt_rdData;

	// unmapped addresses read as zero
	always_comb begin
		nxt_rdData = rdData_ff;
		if (regRdEn) begin
			nxt_rdData = 8'h00;
			for (int i = 0; i < `LSCR_NUM_LDO; i++) begin
				if (regAddr == lscrAddrOf(i)) begin
					nxt_rdData = ctrl_ff[i];
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdData_ff <= 8'h00;
		end else begin
			rdData_ff <= nxt_rdData;
		end
	end

	// ---------------------------------------------------------------
	// fault monitoring
	// ---------------------------------------------------------------
	lscr_mon_if monBus ();

	assign monBus.ldoOn = enable_ff;
	assign monBus.ocLevel = syncVec[2:1];
	assign monBus.uvLevel = syncVec[4:3];
	assign monBus.ocClear = ocClear;
	assign monBus.uvClear = uvClear;

	lscr_event_mon u_mon (
		.mclk(mclk),
		.rst(rst),
		.mon(monBus)
	);

	// ---------------------------------------------------------------
	// third regulator current to the adc
	// ---------------------------------------------------------------
	logic [`LSCR_CUR_W-1:0] curData_ff, nxt_curData;
	logic curValid_ff, nxt_curValid;

	// held between samples so the adc may read it at leisure
	always_comb begin
		nxt_curValid = thirdCurrentValid;
		nxt_curData = thirdCurrentValid ? thirdCurrentIn : curData_ff;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			curData_ff <= '0;
			curValid_ff <= 1'b0;
		end else begin
			curData_ff <= nxt_curData;
			curValid_ff <= nxt_curValid;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign regRdData = rdData_ff;
	assign ldoEnable = enable_ff;
	assign ldoLowPower = lowPower_ff;
	assign ldoDischarge = discharge_ff;
	assign ocFlag = monBus.ocFlag;
	assign uvFlag = monBus.uvFlag;
	assign adcCurrentData = curData_ff;
	assign adcCurrentValid = curValid_ff;

endmodule

`default_nettype wire

// ==== src/lscr_cfg.svh ====
`ifndef LSCR_CFG_SVH
`define LSCR_CFG_SVH
// Behaviour
// - reference_ldo_control: read/write 8 bits at 0x3F, resets 0x24, live 2:0, exit 5:3.
// - second_ldo_control: read/write 8 bits at 0x40, resets 0x3C, same layout.
// - state codes: 4 off, 5 low power, 6 and 7 active; live 0-3 reserved.
// - exit codes 0 to 3 mean no copy on standby exit.
// - standby exit loads each exit field into its live field.
// - each regulator has its own register and independent control.
// - off state enables active discharge of that output.
// - each output is monitored for over-current and under-voltage, events flagged.
// - third regulator current measurement is passed to the ADC subsystem.
// - reference regulator enters low power only by software code, never automatically.

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define LSCR_ADDR_W 8
`define LSCR_DATA_W 8
`define LSCR_REF_ADDR 8'h3F
`define LSCR_SEC_ADDR 8'h40
`define LSCR_REF_RESET 8'h24
`define LSCR_SEC_RESET 8'h3C

// ---------------------------------------------------------------
// fields and codes
// ---------------------------------------------------------------
`define LSCR_LIVE_LSB 0
`define LSCR_LIVE_MSB 2
`define LSCR_EXIT_LSB 3
`define LSCR_EXIT_MSB 5
`define LSCR_CODE_OFF 3'h4
`define LSCR_CODE_LOWPWR 3'h5
`define LSCR_CODE_ACT_A 3'h6
`define LSCR_CODE_ACT_B 3'h7

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define LSCR_NUM_LDO 2
`define LSCR_SYNC_W 5
`define LSCR_CUR_W 10

`endif

// ==== src/lscr_pkg.sv ====
`include "lscr_cfg.svh"

package lscr_pkg;

	typedef logic [2:0] lscr_code_t;

	typedef struct packed {
		logic [1:0] rsvd;
		lscr_code_t exitCode;
		lscr_code_t liveCode;
	} lscr_ctrl_s;

	// codes 4..7 carry a state; 0..3 are reserved or "no copy"
	function automatic logic lscrIsRunCode(input lscr_code_t code);
		return code[2];
	endfunction

	function automatic logic [7:0] lscrAddrOf(input int idx);
		return (idx == 0) ? `LSCR_REF_ADDR : `LSCR_SEC_ADDR;
	endfunction

	function automatic logic [7:0] lscrResetOf(input int idx);
		return (idx == 0) ? `LSCR_REF_RESET : `LSCR_SEC_RESET;
	endfunction

endpackage

// ==== src/lscr_mon_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface lscr_mon_if;
	logic [1:0] ldoOn;
	logic [1:0] ocLevel;
	logic [1:0] uvLevel;
	logic [1:0] ocClear;
	logic [1:0] uvClear;
	logic [1:0] ocFlag;
	logic [1:0] uvFlag;

	modport ctrl(output ldoOn, output ocLevel, output uvLevel, output ocClear, output uvClear,
		input ocFlag, input uvFlag);
	modport mon(input ldoOn, input ocLevel, input uvLevel, input ocClear, input uvClear,
		output ocFlag, output uvFlag);
endinterface

`default_nettype wire

// ==== src/lscr_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "lscr_cfg.svh"

module lscr_pin_sync
	import lscr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [`LSCR_SYNC_W-1:0] asyncIn,
	output logic [`LSCR_SYNC_W-1:0] syncOut
);

	logic [`LSCR_SYNC_W-1:0] stage1_ff, stage2_ff, stage3_ff, level_ff;
	logic [`LSCR_SYNC_W-1:0] nxt_stage1, nxt_stage2, nxt_stage3, nxt_level;

	// a change counts only once stages two and three agree
	always_comb begin
		nxt_stage1 = asyncIn;
		nxt_stage2 = stage1_ff;
		nxt_stage3 = stage2_ff;
		nxt_level = level_ff;
		for (int i = 0; i < `LSCR_SYNC_W; i++) begin
			if (stage2_ff[i] == stage3_ff[i]) begin
				nxt_level[i] = stage3_ff[i];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
			level_ff <= '0;
		end else begin
			stage1_ff <= nxt_stage1;
			stage2_ff <= nxt_stage2;
			stage3_ff <= nxt_stage3;
			level_ff <= nxt_level;
		end
	end

	assign syncOut = level_ff;

endmodule

`default_nettype wire

// ==== src/lscr_event_mon.sv ====
`timescale 1ns/10ps
`default_nettype none

module lscr_event_mon
	import lscr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	lscr_mon_if.mon mon
);

	logic [1:0] ocFlag_ff, uvFlag_ff, nxt_ocFlag, nxt_uvFlag;

	// comparators on a switched-off rail are meaningless, so only live rails flag
	always_comb begin
		nxt_ocFlag = (ocFlag_ff & ~mon.ocClear) | (mon.ocLevel & mon.ldoOn);
		nxt_uvFlag = (uvFlag_ff & ~mon.uvClear) | (mon.uvLevel & mon.ldoOn);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ocFlag_ff <= '0;
			uvFlag_ff <= '0;
		end else begin
			ocFlag_ff <= nxt_ocFlag;
			uvFlag_ff <= nxt_uvFlag;
		end
	end

	assign mon.ocFlag = ocFlag_ff;
	assign mon.uvFlag = uvFlag_ff;

endmodule

`default_nettype wire

// ==== sim/lscr_top_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module lscr_top_monitor
	import lscr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic [1:0] ldoEnable,
	input wire logic [1:0] ldoLowPower,
	input wire logic [1:0] ldoDischarge,
	input wire logic [1:0] ocFlag,
	input wire logic [1:0] ocClear,
	input wire logic [9:0] thirdCurrentIn,
	input wire logic thirdCurrentValid,
	input wire logic [9:0] adcCurrentData,
	input wire logic adcCurrentValid
);
	// --------
	// port rules
	// --------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic wrRef;
	logic wrSec;
	assign wrRef = regWrEn && regAddr == 8'h3F;
	assign wrSec = regWrEn && regAddr == 8'h40;
	property p_rdTop; regRdEn |=> regRdData[7:6] == 2'h0; endproperty
	a_rdTop: assert property (p_rdTop) else $error("top bits set");
	property p_unmap; regRdEn && regAddr != 8'h3F && regAddr != 8'h40 |=> regRdData == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_dis; ldoDischarge == ~ldoEnable; endproperty
	a_dis: assert property (p_dis) else $error("discharge wrong");
	property p_lp; (ldoLowPower & ~ldoEnable) == 2'h0; endproperty
	a_lp: assert property (p_lp) else $error("low power while off");
	property p_wrLp; wrSec && regWrData[2:0] == 3'h5 |=> ldoLowPower[1] && ldoEnable[1]; endproperty
	a_wrLp: assert property (p_wrLp) else $error("low power code");
	property p_wrOff; wrRef && regWrData[2:0] == 3'h4 |=> ldoDischarge[0]; endproperty
	a_wrOff: assert property (p_wrOff) else $error("off code");
	property p_rsvd; wrRef && !regWrData[2] |=> $stable(ldoEnable[0]) && $stable(ldoLowPower[0]); endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved code taken");
	property p_indep; wrRef |=> $stable(ldoEnable[1]) && $stable(ldoLowPower[1]); endproperty
	a_indep: assert property (p_indep) else $error("second rail moved");
	property p_ocOn; $rose(ocFlag[0]) |-> $past(ldoEnable[0]); endproperty
	a_ocOn: assert property (p_ocOn) else $error("flag on off rail");
	property p_ocHold; ocFlag[0] && !ocClear[0] |=> ocFlag[0]; endproperty
	a_ocHold: assert property (p_ocHold) else $error("flag lost");
	property p_adc; thirdCurrentValid |=> adcCurrentValid && adcCurrentData == $past(thirdCurrentIn); endproperty
	a_adc: assert property (p_adc) else $error("current sample");
	property p_adcOne; !thirdCurrentValid |=> !adcCurrentValid; endproperty
	a_adcOne: assert property (p_adcOne) else $error("stray valid");
	c_oc: cover property ($rose(ocFlag[0]));
	c_copy: cover property ($rose(ldoLowPower[0]) && !$past(regWrEn));
	c_adc: cover property (adcCurrentValid);
endmodule
bind lscr_top lscr_top_monitor mon_u (.mclk(mclk), .rst(rst), .regAddr(regAddr),
	.regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
	.ldoEnable(ldoEnable), .ldoLowPower(ldoLowPower), .ldoDischarge(ldoDischarge),
	.ocFlag(ocFlag), .ocClear(ocClear), .thirdCurrentIn(thirdCurrentIn),
	.thirdCurrentValid(thirdCurrentValid), .adcCurrentData(adcCurrentData),
	.adcCurrentValid(adcCurrentValid));
`default_nettype wire

// ==== sim/lscr_spi_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lscr_spi_host (
	input wire logic mclk,
	output logic [7:0] regAddr,
	output logic regWrEn,
	output logic regRdEn,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData
);
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regWrData = 8'h00;
	end
	// released lines show inverted values, not the last ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge mclk);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge mclk);
		regRdEn = 1'b0;
		regAddr = ~a;
		@(negedge mclk);
		d = regRdData;
	endtask
endmodule
`default_nettype wire

// ==== sim/ldo_state_control_regs_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module ldo_state_control_regs_test;
	import lscr_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic pin = 1'b0;
	logic [1:0] ocIn = 2'h0;
	logic [1:0] uvIn = 2'h0;
	logic [1:0] ocClr = 2'h0;
	logic [1:0] uvClr = 2'h0;
	logic [9:0] curIn = 10'h000;
	logic curVal = 1'b0;
	logic [7:0] regAddr, regWrData, regRdData, rdVal;
	logic regWrEn, regRdEn, adcVal;
	logic [1:0] en, lp, dis, ocFlag, uvFlag;
	logic [9:0] adcData;
	int miscompares = 0;
	int testsRun = 0;
	always #2.5 mclk = ~mclk;
	lscr_spi_host host_u (.mclk(mclk), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData));
	lscr_top dut_u (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
		.standbyExitPin(pin), .overCurrentIn(ocIn), .underVoltageIn(uvIn), .ocClear(ocClr),
		.uvClear(uvClr), .ldoEnable(en), .ldoLowPower(lp), .ldoDischarge(dis), .ocFlag(ocFlag),
		.uvFlag(uvFlag), .thirdCurrentIn(curIn), .thirdCurrentValid(curVal),
		.adcCurrentData(adcData), .adcCurrentValid(adcVal));
	// --------
	// checks
	// --------
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		testsRun++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic t_reset();
		chk("outs", 6'h03, {en, lp, dis});
		host_u.rd(8'h3F, rdVal);
		chk("ref", 8'h24, rdVal);
		host_u.rd(8'h40, rdVal);
		chk("sec", 8'h3C, rdVal);
	endtask
	task automatic t_codes();
		for (int c = 4; c < 8; c++) begin
			host_u.wr(8'h3F, {5'b1_1101, c[2:0]});
			chk("outs", {1'b0, c != 4, 1'b0, c == 5, 1'b1, c == 4}, {en, lp, dis});
			host_u.rd(8'h3F, rdVal);
			chk("ref", {5'b0_0101, c[2:0]}, rdVal);
		end
	endtask
	task automatic t_second();
		host_u.wr(8'h40, 8'hED);
		chk("outs", 6'b11_1000, {en, lp, dis});
		host_u.rd(8'h40, rdVal);
		chk("sec", 8'h2D, rdVal);
		host_u.wr(8'h3F, 8'h32);
		chk("outs", 6'b11_1000, {en, lp, dis});
		host_u.rd(8'h3F, rdVal);
		chk("ref", 8'h37, rdVal);
		host_u.wr(8'h41, 8'h00);
		host_u.rd(8'h41, rdVal);
		chk("unmapped", 8'h00, rdVal);
		host_u.rd(8'h40, rdVal);
		chk("sec", 8'h2D, rdVal);
	endtask
	task automatic t_exit();
		host_u.wr(8'h3F, 8'h2E);
		host_u.wr(8'h40, 8'h07);
		@(negedge mclk);
		pin = 1'b1;
		repeat (7) @(negedge mclk);
		chk("outs", 6'b11_0100, {en, lp, dis});
		host_u.rd(8'h40, rdVal);
		chk("sec", 8'h07, rdVal);
		host_u.wr(8'h3F, 8'h2E);
		repeat (8) @(negedge mclk);
		chk("outs", 6'b11_0000, {en, lp, dis});
		pin = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
	task automatic t_fault();
		ocIn = 2'h1;
		repeat (7) @(negedge mclk);
		ocIn = 2'h0;
		repeat (7) @(negedge mclk);
		chk("oc", 2'h1, ocFlag);
		ocClr = 2'h1;
		@(negedge mclk);
		ocClr = 2'h0;
		chk("oc", 2'h0, ocFlag);
		host_u.wr(8'h40, 8'h04);
		uvIn = 2'h3;
		repeat (7) @(negedge mclk);
		uvIn = 2'h0;
		chk("uv", 2'h1, uvFlag);
		uvClr = 2'h1;
		repeat (7) @(negedge mclk);
		uvClr = 2'h0;
		chk("uv", 2'h0, uvFlag);
	endtask
	task automatic t_adc();
		@(negedge mclk);
		curIn = 10'h2A5;
		curVal = 1'b1;
		@(negedge mclk);
		curIn = 10'h15A;
		chk("adc", 11'h6A5, {adcVal, adcData});
		@(negedge mclk);
		curVal = 1'b0;
		chk("adc", 11'h55A, {adcVal, adcData});
		@(negedge mclk);
		chk("adcValid", 1'b0, adcVal);
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		t_reset();
		t_codes();
		t_second();
		t_exit();
		t_fault();
		t_adc();
		results();
	end
	initial begin
		#5000;
		miscompares++;
		results();
	end
endmodule
`default_nettype wire
